//--- hdl/dma_chan_pkg.sv
// Package for the single DMA channel: register map, control fields, types.
// Assumes a 32-bit AHB-Lite register port and a simple request/ack system bus.
package dma_chan_pkg;

  // Printed register offsets; each is a word index, byte address is index times four
  localparam logic [31:0] CH3_CONTROL_OFS = 32'h5000353C;
  localparam logic [31:0] CH3_ITEM_INDEX_OFS = 32'h5000353E;
  localparam logic [31:0] SOURCE_START_LOW_OFS = 32'h50003540;
  localparam logic [31:0] SOURCE_START_HIGH_OFS = 32'h50003542;
  localparam logic [31:0] DEST_START_LOW_OFS = 32'h50003544;
  localparam logic [31:0] DEST_START_HIGH_OFS = 32'h50003546;
  localparam logic [31:0] IRQ_THRESHOLD_OFS = 32'h50003548;
  localparam logic [31:0] TRANSFER_LENGTH_OFS = 32'h5000354A;
  localparam logic [31:0] CHANNEL_CONTROL_OFS = 32'h5000354C;
  localparam logic [31:0] ITEM_INDEX_OFS = 32'h5000354E;

  // Channel control fields
  localparam int ON_BIT = 0;
  localparam int WIDTH_LSB = 1;
  localparam int IRQ_EN_BIT = 3;
  localparam int TRIG_BIT = 4;
  localparam int DINC_BIT = 5;
  localparam int SINC_BIT = 6;
  localparam int CIRC_BIT = 7;
  localparam int PRIO_LSB = 8;
  localparam int IDLE_BIT = 11;
  localparam int FILL_BIT = 12;
  localparam int SENSE_BIT = 13;
  localparam logic [15:0] CTRL_WMASK = 16'h3FFF;
  localparam logic [15:0] REG_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10,
    ST_GAP = 2'b11
  } fsm_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mst_req_t;

endpackage

//--- hdl/dma_channel_control.sv
// Single register-controlled DMA channel with AHB-Lite register slave.
// Assumes a system bus that holds each request until a one-cycle ack and a
// competing lower-numbered channel that reports its request on chan3_req.
// Functional notes
// [RQ1] Width code 00 is 1 byte, 01 is 2, 10 is 4; 11 reserved.
// [RQ2] Channel-on 0 keeps channel idle and clocks gated; writing 1 enables.
// [RQ3] Hardware clears channel-on at completion in normal mode; circular keeps it. Code keeps it only in circular request-triggered mode.
// [RQ4] Read-only item index counts items, returns to zero at completion.
// [RQ5] Next addresses come from index, increment bits and item width.
// [RQ6] Source start address is two writable 16-bit halves.
// [RQ7] Destination start address is two writable 16-bit halves.
// [RQ8] Interrupt after an item when threshold equals index before increment.
// [RQ9] Threshold interrupt only while interrupt enable is one.
// [RQ10] Length N moves N plus one items.
// [RQ11] Sense 0 means level requests, 1 means rising-edge requests.
// [RQ12] Fill mode reads source once, writes it to every destination.
// [RQ13] A running fill is never preempted by another channel.
// [RQ14] Software avoids fill mode together with request-triggered mode.
// [RQ15] Idle bit 0: back-to-back copies, lower masters locked out.
// [RQ16] Idle bit 1: one wait cycle after each store.
// [RQ17] Idle setting ignored when request-triggered.
// [RQ18] Three-bit priority, higher value wins the bus.
// [RQ19] Equal priority: lower-numbered channel wins.
// [RQ20] Circular restarts with index reset; normal stops after length. Code restarts only in circular request-triggered mode.
// [RQ21] Source increment adds 1, 2 or 4 per item, else constant.
// [RQ22] Destination increment adds 1, 2 or 4 per item, else constant.
// [RQ23] Request mode 0 starts at once; 1 waits for peripheral requests.
// [RQ24] Interrupt enable bit 3: 0 suppresses, 1 allows.
// [RQ25] Each item is one read then one same-width write.
// [RQ26] Software programs everything before enabling, avoids reserved width.
`timescale 1ns/100ps
module dma_channel_control (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire dma_chan_pkg::ahb_req_t ahb_in,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output dma_chan_pkg::mst_req_t mst_out,
  input wire logic mst_ack,
  input wire logic [31:0] mst_rdata,
  input wire logic periph_request,
  input wire logic chan3_req,
  input wire logic [15:0] chan3_index,
  output logic bus_lock,
  output logic irq,
  output logic chan_clk_en
);

  typedef struct packed {
    dma_chan_pkg::fsm_t fsm;
    logic [15:0] ctrl;
    logic [15:0] c3ctrl;
    logic [15:0] src_lo;
    logic [15:0] src_hi;
    logic [15:0] dst_lo;
    logic [15:0] dst_hi;
    logic [15:0] thr;
    logic [15:0] len;
    logic [15:0] idx;
    logic [31:0] data;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic edge_pend;
    dma_chan_pkg::mst_req_t mst;
    logic lock;
    logic irq;
    logic clk_en;
    logic ap_valid;
    logic ap_write;
    logic [9:0] ap_idx;
    logic [31:0] rdata;
    logic ready;
  } state_t;

  state_t s_reg;
  state_t s_next;

  function automatic logic [2:0] width_bytes(input logic [1:0] code);
    case (code)
      2'b00: width_bytes = 3'h1; // [RQ1]
      2'b01: width_bytes = 3'h2; // [RQ1]
      2'b10: width_bytes = 3'h4; // [RQ1]
      default: width_bytes = 3'h0;
    endcase
  endfunction

  // Start address plus index times step, or start when not incrementing
  function automatic logic [31:0] addr_at(input logic [31:0] base, input logic [15:0] index,
                                          input logic inc, input logic [1:0] code);
    logic [31:0] step;
    step = {29'h0, width_bytes(code)};
    addr_at = inc ? base + 32'(index) * step : base; // [RQ5] [RQ21] [RQ22]
  endfunction

  // Only the low ten bits of a printed index are decoded
  function automatic logic reg_hit(input logic [9:0] ai, input logic [31:0] ofs);
    reg_hit = (ai == ofs[9:0]);
  endfunction

  logic trig_mode;
  logic fill_mode;
  logic idle_eff;
  logic rise;
  logic trigger_ok;
  logic wins;
  logic item_done;
  logic last_item;
  logic ctrl_wr;
  logic [31:0] src_start;
  logic [31:0] dst_start;

  assign trig_mode = s_reg.ctrl[dma_chan_pkg::TRIG_BIT];
  assign fill_mode = s_reg.ctrl[dma_chan_pkg::FILL_BIT];
  assign idle_eff = s_reg.ctrl[dma_chan_pkg::IDLE_BIT] & ~trig_mode; // [RQ17]
  assign rise = s_reg.req_s2 & ~s_reg.req_s3;
  assign src_start = {s_reg.src_hi, s_reg.src_lo};
  assign dst_start = {s_reg.dst_hi, s_reg.dst_lo};
  assign item_done = (s_reg.fsm == dma_chan_pkg::ST_WRITE) & mst_ack;
  assign last_item = (s_reg.idx == s_reg.len); // [RQ10]
  assign ctrl_wr = s_reg.ap_valid & s_reg.ap_write &
                   reg_hit(s_reg.ap_idx, dma_chan_pkg::CHANNEL_CONTROL_OFS);

  always_comb begin
    if (!trig_mode) begin
      trigger_ok = 1'b1; // [RQ23]
    end else if (s_reg.ctrl[dma_chan_pkg::SENSE_BIT]) begin
      trigger_ok = s_reg.edge_pend; // [RQ11]
    end else begin
      trigger_ok = s_reg.req_s2; // [RQ11]
    end
  end

  // Tie goes to the lower-numbered channel 3; a running fill keeps the bus
  assign wins = ~(chan3_req & s_reg.c3ctrl[dma_chan_pkg::ON_BIT]) | // [RQ18]
                (fill_mode & (s_reg.idx != 16'h0000)) | // [RQ13]
                (s_reg.ctrl[dma_chan_pkg::PRIO_LSB +: 3] >
                 s_reg.c3ctrl[dma_chan_pkg::PRIO_LSB +: 3]); // [RQ18] [RQ19]

  always_comb begin
    s_next = s_reg;
    s_next.irq = 1'b0;
    s_next.req_s1 = periph_request;
    s_next.req_s2 = s_reg.req_s1;
    s_next.req_s3 = s_reg.req_s2;
    // Set beats consume so a coinciding edge is kept
    s_next.edge_pend = rise | s_reg.edge_pend;

    case (s_reg.fsm)
      dma_chan_pkg::ST_IDLE: begin
        if (!s_reg.ctrl[dma_chan_pkg::ON_BIT]) begin
          s_next.idx = 16'h0000; // [RQ2]
          s_next.lock = 1'b0;
        end else if (trigger_ok && wins) begin
          s_next.edge_pend = rise;
          s_next.mst.req = 1'b1;
          s_next.mst.size = s_reg.ctrl[dma_chan_pkg::WIDTH_LSB +: 2];
          s_next.lock = ~idle_eff; // [RQ15]
          if (fill_mode && s_reg.idx != 16'h0000) begin
            s_next.fsm = dma_chan_pkg::ST_WRITE; // [RQ12]
            s_next.mst.write = 1'b1;
            s_next.mst.wdata = s_reg.data;
            s_next.mst.addr = addr_at(dst_start, s_reg.idx,
                                      s_reg.ctrl[dma_chan_pkg::DINC_BIT],
                                      s_reg.ctrl[dma_chan_pkg::WIDTH_LSB +: 2]);
          end else begin
            s_next.fsm = dma_chan_pkg::ST_READ; // [RQ25]
            s_next.mst.write = 1'b0;
            s_next.mst.addr = addr_at(src_start, s_reg.idx,
                                      s_reg.ctrl[dma_chan_pkg::SINC_BIT] & ~fill_mode,
                                      s_reg.ctrl[dma_chan_pkg::WIDTH_LSB +: 2]); // [RQ12]
          end
        end
      end
      dma_chan_pkg::ST_READ: begin
        if (mst_ack) begin
          s_next.fsm = dma_chan_pkg::ST_WRITE; // [RQ25]
          s_next.data = mst_rdata;
          s_next.mst.write = 1'b1;
          s_next.mst.wdata = mst_rdata;
          s_next.mst.addr = addr_at(dst_start, s_reg.idx,
                                    s_reg.ctrl[dma_chan_pkg::DINC_BIT],
                                    s_reg.ctrl[dma_chan_pkg::WIDTH_LSB +: 2]); // [RQ22]
        end
      end
      dma_chan_pkg::ST_WRITE: begin
        if (mst_ack) begin
          s_next.mst.req = 1'b0;
          s_next.mst.write = 1'b0;
          // Compared before the index moves on
          s_next.irq = s_reg.ctrl[dma_chan_pkg::IRQ_EN_BIT] &
                       (s_reg.thr == s_reg.idx); // [RQ8] [RQ9] [RQ24]
          s_next.fsm = idle_eff ? dma_chan_pkg::ST_GAP : dma_chan_pkg::ST_IDLE; // [RQ16]
          if (last_item) begin
            s_next.idx = 16'h0000; // [RQ4] [RQ20]
            s_next.lock = 1'b0;
            if (!(s_reg.ctrl[dma_chan_pkg::CIRC_BIT] && trig_mode)) begin
              s_next.ctrl[dma_chan_pkg::ON_BIT] = 1'b0; // [RQ3] [RQ20]
            end
          end else begin
            s_next.idx = s_reg.idx + 16'h0001; // [RQ4]
          end
        end
      end
      dma_chan_pkg::ST_GAP: begin
        s_next.fsm = dma_chan_pkg::ST_IDLE; // [RQ16]
      end
      default: begin
        s_next.fsm = dma_chan_pkg::ST_IDLE;
      end
    endcase

    // Data phase write; applied after the engine so a software set of the
    // on bit wins over a completion clear in the same cycle
    if (s_reg.ap_valid && s_reg.ap_write) begin
      if (reg_hit(s_reg.ap_idx, dma_chan_pkg::CH3_CONTROL_OFS)) begin
        s_next.c3ctrl = ahb_in.hwdata[15:0] & dma_chan_pkg::CTRL_WMASK;
      end
      if (reg_hit(s_reg.ap_idx, dma_chan_pkg::SOURCE_START_LOW_OFS)) begin
        s_next.src_lo = ahb_in.hwdata[15:0]; // [RQ6]
      end
      if (reg_hit(s_reg.ap_idx, dma_chan_pkg::SOURCE_START_HIGH_OFS)) begin
        s_next.src_hi = ahb_in.hwdata[15:0]; // [RQ6]
      end
      if (reg_hit(s_reg.ap_idx, dma_chan_pkg::DEST_START_LOW_OFS)) begin
        s_next.dst_lo = ahb_in.hwdata[15:0]; // [RQ7]
      end
      if (reg_hit(s_reg.ap_idx, dma_chan_pkg::DEST_START_HIGH_OFS)) begin
        s_next.dst_hi = ahb_in.hwdata[15:0]; // [RQ7]
      end
      if (reg_hit(s_reg.ap_idx, dma_chan_pkg::IRQ_THRESHOLD_OFS)) begin
        s_next.thr = ahb_in.hwdata[15:0];
      end
      if (reg_hit(s_reg.ap_idx, dma_chan_pkg::TRANSFER_LENGTH_OFS)) begin
        s_next.len = ahb_in.hwdata[15:0];
      end
      if (ctrl_wr) begin
        s_next.ctrl = ahb_in.hwdata[15:0] & dma_chan_pkg::CTRL_WMASK; // [RQ2]
      end
    end
    s_next.clk_en = s_next.ctrl[dma_chan_pkg::ON_BIT]; // [RQ2]

    // Address phase; read data comes from post-write values, zero wait
    s_next.ap_valid = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready;
    s_next.ap_write = ahb_in.hwrite;
    s_next.ap_idx = ahb_in.haddr[11:2];
    s_next.ready = 1'b1;
    s_next.rdata = 32'h0000_0000;
    if (s_next.ap_valid && !ahb_in.hwrite) begin
      if (reg_hit(s_next.ap_idx, dma_chan_pkg::CH3_CONTROL_OFS)) begin
        s_next.rdata[15:0] = s_next.c3ctrl;
      end else if (reg_hit(s_next.ap_idx, dma_chan_pkg::CH3_ITEM_INDEX_OFS)) begin
        s_next.rdata[15:0] = chan3_index;
      end else if (reg_hit(s_next.ap_idx, dma_chan_pkg::SOURCE_START_LOW_OFS)) begin
        s_next.rdata[15:0] = s_next.src_lo;
      end else if (reg_hit(s_next.ap_idx, dma_chan_pkg::SOURCE_START_HIGH_OFS)) begin
        s_next.rdata[15:0] = s_next.src_hi;
      end else if (reg_hit(s_next.ap_idx, dma_chan_pkg::DEST_START_LOW_OFS)) begin
        s_next.rdata[15:0] = s_next.dst_lo;
      end else if (reg_hit(s_next.ap_idx, dma_chan_pkg::DEST_START_HIGH_OFS)) begin
        s_next.rdata[15:0] = s_next.dst_hi;
      end else if (reg_hit(s_next.ap_idx, dma_chan_pkg::IRQ_THRESHOLD_OFS)) begin
        s_next.rdata[15:0] = s_next.thr;
      end else if (reg_hit(s_next.ap_idx, dma_chan_pkg::TRANSFER_LENGTH_OFS)) begin
        s_next.rdata[15:0] = s_next.len;
      end else if (reg_hit(s_next.ap_idx, dma_chan_pkg::CHANNEL_CONTROL_OFS)) begin
        s_next.rdata[15:0] = s_next.ctrl;
      end else if (reg_hit(s_next.ap_idx, dma_chan_pkg::ITEM_INDEX_OFS)) begin
        s_next.rdata[15:0] = s_next.idx; // [RQ4]
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = s_reg.ready;
  assign hresp = 1'b0 & s_reg.ready;
  assign hrdata = s_reg.rdata;
  assign mst_out = s_reg.mst;
  assign bus_lock = s_reg.lock;
  assign irq = s_reg.irq;
  assign chan_clk_en = s_reg.clk_en;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  on_clear_a: assert property ( // [RQ3]
    (item_done && last_item && !ctrl_wr &&
     !(s_reg.ctrl[dma_chan_pkg::CIRC_BIT] && trig_mode))
    |=> !s_reg.ctrl[dma_chan_pkg::ON_BIT] && !chan_clk_en)
    else $error("channel-on not cleared at completion");

  idx_wrap_a: assert property ( // [RQ4]
    item_done && last_item |=> s_reg.idx == 16'h0000)
    else $error("item index not zero after completion");

  irq_cause_a: assert property ( // [RQ8]
    item_done && s_reg.ctrl[dma_chan_pkg::IRQ_EN_BIT] && s_reg.thr == s_reg.idx
    |=> irq ##1 !irq)
    else $error("threshold interrupt missing or too long");

  irq_gate_a: assert property ( // [RQ9]
    irq |-> $past(item_done) && $past(s_reg.ctrl[dma_chan_pkg::IRQ_EN_BIT]))
    else $error("interrupt without enable or item end");

  read_write_a: assert property ( // [RQ25]
    s_reg.fsm == dma_chan_pkg::ST_READ && mst_ack
    |=> mst_out.req && mst_out.write && $stable(mst_out.size)
        && mst_out.wdata == $past(mst_rdata))
    else $error("read not followed by same-width write");

  store_gap_a: assert property ( // [RQ16]
    item_done && idle_eff |=> !mst_out.req ##1 !mst_out.req)
    else $error("no wait cycle after store");

  fill_once_a: assert property ( // [RQ12]
    mst_out.req && !mst_out.write && fill_mode |-> s_reg.idx == 16'h0000)
    else $error("fill mode read source twice");

  src_addr_a: assert property ( // [RQ21]
    mst_out.req && !mst_out.write && !fill_mode && s_reg.ctrl[dma_chan_pkg::SINC_BIT]
    && s_reg.ctrl[dma_chan_pkg::WIDTH_LSB +: 2] == 2'b10
    |-> mst_out.addr == src_start + {s_reg.idx, 2'b00})
    else $error("source address wrong for word items");

  level_wait_a: assert property ( // [RQ11]
    s_reg.fsm == dma_chan_pkg::ST_IDLE && trig_mode && !s_reg.ctrl[dma_chan_pkg::SENSE_BIT]
    && !s_reg.req_s2 |=> !mst_out.req)
    else $error("started without level request");

  off_idle_a: assert property ( // [RQ2]
    s_reg.fsm == dma_chan_pkg::ST_IDLE && !s_reg.ctrl[dma_chan_pkg::ON_BIT] && !ctrl_wr
    |=> !mst_out.req [*2])
    else $error("disabled channel used the bus");

endmodule // dma_channel_control

//--- tb/sys_bus_model.sv
// System bus memory model for the DMA channel's master port.
// Assumes the channel holds each request until the one-cycle ack.
`timescale 1ns/100ps
module sys_bus_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire dma_chan_pkg::mst_req_t mst_out,
  input wire logic [3:0] ack_delay,
  output logic mst_ack,
  output logic [31:0] mst_rdata
);
  logic [31:0] la[$];
  logic [31:0] ld[$];
  logic lw[$];
  logic [1:0] ls[$];
  logic [3:0] cnt;
  logic [31:0] rv;

  // Read data depends on address so every item is distinguishable
  assign rv = {~mst_out.addr[15:0], mst_out.addr[15:0]};

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mst_ack <= 1'b0;
      mst_rdata <= 32'h00000000;
      cnt <= 4'h0;
    end else if (mst_ack) begin
      mst_ack <= 1'b0;
      mst_rdata <= ~mst_rdata;
    end else if (mst_out.req && cnt >= ack_delay) begin
      mst_ack <= 1'b1;
      cnt <= 4'h0;
      mst_rdata <= mst_out.write ? ~mst_rdata : rv;
      la.push_back(mst_out.addr);
      ld.push_back(mst_out.write ? mst_out.wdata : rv);
      lw.push_back(mst_out.write);
      ls.push_back(mst_out.size);
    end else begin
      // Stale data flips so nothing outside an ack can look valid
      mst_rdata <= ~mst_rdata;
      if (mst_out.req)
        cnt <= cnt + 4'h1;
    end
  end
endmodule // sys_bus_model

//--- tb/tb.sv
// Testbench: register access and DMA runs against the bus memory model.
// Assumes a zero-wait AHB-Lite register slave and a held bus request.
`timescale 1ns/100ps
module tb;
  localparam logic [31:0] IDX4_OFS = 32'h5000354E;
  localparam logic [31:0] SRC = 32'h20000100;
  localparam logic [31:0] DST = 32'h20000800;
  localparam logic [31:0] RW_OFS [7] = '{dma_chan_pkg::SOURCE_START_LOW_OFS,
    dma_chan_pkg::SOURCE_START_HIGH_OFS, dma_chan_pkg::DEST_START_LOW_OFS,
    dma_chan_pkg::DEST_START_HIGH_OFS, dma_chan_pkg::IRQ_THRESHOLD_OFS,
    dma_chan_pkg::TRANSFER_LENGTH_OFS, dma_chan_pkg::CH3_CONTROL_OFS};
  localparam logic [15:0] CT [4] = '{16'h006C, 16'h0040, 16'h082A, 16'h106C};
  localparam logic [15:0] LN [4] = '{16'h0002, 16'h0001, 16'h0000, 16'h0003};
  localparam logic [15:0] TH [4] = '{16'h0001, 16'h0000, 16'h0000, 16'h0005};
  localparam logic [3:0] DLY [4] = '{4'h0, 4'h3, 4'h1, 4'h2};
  localparam logic [2:0] P3 [3] = '{3'h7, 3'h3, 3'h3};
  localparam logic [2:0] PO [3] = '{3'h0, 3'h3, 3'h7};
  localparam logic BLK [3] = '{1'b1, 1'b1, 1'b0};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  dma_chan_pkg::ahb_req_t ahb_r = '0;
  dma_chan_pkg::ahb_req_t ahb_in;
  dma_chan_pkg::mst_req_t mst_out;
  logic hreadyout, hresp, mst_ack, bus_lock, irq, chan_clk_en;
  logic [31:0] hrdata, mst_rdata, rd;
  logic periph_request = 1'b0;
  logic chan3_req = 1'b0;
  logic [3:0] ack_delay = 4'h0;
  int mismatches = 0;
  int total_checks = 0;
  int irq_cnt = 0;
  int lock_cnt = 0;

  always #12.5 core_clk = ~core_clk;
  always_comb begin
    ahb_in = ahb_r;
    ahb_in.hready = hreadyout;
  end
  always @(posedge core_clk) begin
    if (irq === 1'b1) irq_cnt++;
    if (bus_lock === 1'b1) lock_cnt++;
  end

  dma_channel_control dut (.core_clk(core_clk), .rst_n(rst_n), .ahb_in(ahb_in),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mst_out(mst_out),
    .mst_ack(mst_ack), .mst_rdata(mst_rdata), .periph_request(periph_request),
    .chan3_req(chan3_req), .chan3_index(16'h5A17), .bus_lock(bus_lock), .irq(irq),
    .chan_clk_en(chan_clk_en));
  sys_bus_model mem (.core_clk(core_clk), .rst_n(rst_n), .mst_out(mst_out),
    .ack_delay(ack_delay), .mst_ack(mst_ack), .mst_rdata(mst_rdata));

  task print_verdict;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task tmo;
    mismatches++;
    $display("timeout at %0t", $time);
    print_verdict();
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) tmo();
  endtask
  // Entered just after a rising edge; every bus signal changes by NBA
  task ahb(input logic wr_en, input logic [31:0] ofs, input logic [15:0] wd);
    ahb_r.hsel <= 1'b1;
    ahb_r.htrans <= 2'b10;
    ahb_r.haddr <= {ofs[29:0], 2'b00};
    ahb_r.hwrite <= wr_en;
    ahb_r.hsize <= 3'b010;
    wait_rdy();
    ahb_r.hsel <= 1'b0;
    ahb_r.htrans <= 2'b00;
    ahb_r.hwdata <= {16'h0000, wd};
    wait_rdy();
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask
  task wr(input logic [31:0] ofs, input logic [15:0] d);
    ahb(1'b1, ofs, d);
  endtask
  task rdchk(input logic [31:0] ofs, input logic [15:0] exp);
    ahb(1'b0, ofs, 16'h0000);
    chk(rd, {16'h0000, exp});
  endtask
  task cfg(input logic [15:0] ctrl, input logic [15:0] len, input logic [15:0] thr);
    wr(dma_chan_pkg::SOURCE_START_LOW_OFS, SRC[15:0]);
    wr(dma_chan_pkg::SOURCE_START_HIGH_OFS, SRC[31:16]);
    wr(dma_chan_pkg::DEST_START_LOW_OFS, DST[15:0]);
    wr(dma_chan_pkg::DEST_START_HIGH_OFS, DST[31:16]);
    wr(dma_chan_pkg::IRQ_THRESHOLD_OFS, thr);
    wr(dma_chan_pkg::TRANSFER_LENGTH_OFS, len);
    wr(dma_chan_pkg::CHANNEL_CONTROL_OFS, ctrl);
    mem.la.delete();
    mem.ld.delete();
    mem.lw.delete();
    mem.ls.delete();
    irq_cnt = 0;
    lock_cnt = 0;
  endtask
  task go(input logic [15:0] ctrl);
    wr(dma_chan_pkg::CHANNEL_CONTROL_OFS, ctrl | 16'h0001);
    @(posedge core_clk);
    chk(chan_clk_en, 1'b1);
  endtask
  task verify(input logic [15:0] ctrl, input logic [15:0] len, input logic [15:0] thr);
    int n;
    int r;
    logic [31:0] step, sa, dat;
    n = 0;
    while (chan_clk_en !== 1'b0 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) tmo();
    // Let the pulse counters take the final edge before they are read
    @(posedge core_clk);
    step = 32'h1 << ctrl[2:1];
    r = 0;
    chk(mem.la.size(), ctrl[12] ? len + 2 : 2 * len + 2);
    if (mem.la.size() == (ctrl[12] ? len + 2 : 2 * len + 2)) begin
      for (int i = 0; i <= len; i++) begin
        if (!ctrl[12] || i == 0) begin
          sa = SRC + (ctrl[6] ? i * step : 0);
          dat = {~sa[15:0], sa[15:0]};
          chk(mem.la[r], sa);
          chk({mem.lw[r], mem.ls[r]}, {1'b0, ctrl[2:1]});
          r++;
        end
        chk(mem.la[r], DST + (ctrl[5] ? i * step : 0));
        chk(mem.ld[r], dat);
        chk({mem.lw[r], mem.ls[r]}, {1'b1, ctrl[2:1]});
        r++;
      end
    end
    chk(irq_cnt, ctrl[3] && thr <= len);
    if (!ctrl[4]) chk(lock_cnt != 0, !ctrl[11]);
    rdchk(dma_chan_pkg::CHANNEL_CONTROL_OFS, ctrl);
    rdchk(IDX4_OFS, 16'h0000);
  endtask

  initial begin
    int n;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 7; i++) rdchk(RW_OFS[i], 16'h0000);
    rdchk(dma_chan_pkg::CHANNEL_CONTROL_OFS, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      wr(RW_OFS[i], 16'hA5C3 ^ 16'(i));
      rdchk(RW_OFS[i], (16'hA5C3 ^ 16'(i)) & (i == 6 ? dma_chan_pkg::CTRL_WMASK : 16'hFFFF));
    end
    // Every field but the on bit, so nothing starts
    wr(dma_chan_pkg::CHANNEL_CONTROL_OFS, 16'hFFFE);
    rdchk(dma_chan_pkg::CHANNEL_CONTROL_OFS, 16'h3FFE);
    chk(chan_clk_en, 1'b0);
    wr(IDX4_OFS, 16'hFFFF);
    rdchk(IDX4_OFS, 16'h0000);
    rdchk(dma_chan_pkg::CH3_ITEM_INDEX_OFS, 16'h5A17);
    rdchk(32'h50003560, 16'h0000);
    wr(dma_chan_pkg::CH3_CONTROL_OFS, 16'h0000);
    $display("register test done");
    // Fill case is immediate mode only
    for (int k = 0; k < 4; k++) begin
      ack_delay <= DLY[k];
      cfg(CT[k], LN[k], TH[k]);
      go(CT[k]);
      verify(CT[k], LN[k], TH[k]);
    end
    $display("copy test done");
    ack_delay <= 4'h3;
    for (int k = 0; k < 3; k++) begin
      wr(dma_chan_pkg::CH3_CONTROL_OFS, {5'h00, P3[k], 8'h01});
      chan3_req <= 1'b1;
      cfg({5'h00, PO[k], 8'h64}, 16'h0007, 16'hFFFF);
      go({5'h00, PO[k], 8'h64});
      repeat (30) @(posedge core_clk);
      chk(mem.la.size() != 0, !BLK[k]);
      chan3_req <= 1'b0;
      verify({5'h00, PO[k], 8'h64}, 16'h0007, 16'hFFFF);
    end
    // Channel 3 outranks us but may not cut into a running fill
    cfg(16'h106C, 16'h0003, 16'hFFFF);
    go(16'h106C);
    n = 0;
    while (mem.la.size() == 0 && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 500) tmo();
    chan3_req <= 1'b1;
    verify(16'h106C, 16'h0003, 16'hFFFF);
    chan3_req <= 1'b0;
    wr(dma_chan_pkg::CH3_CONTROL_OFS, 16'h0000);
    $display("priority test done");
    cfg(16'h0874, 16'h0001, 16'hFFFF);
    go(16'h0874);
    repeat (30) @(posedge core_clk);
    chk(mem.la.size(), 0);
    periph_request <= 1'b1;
    verify(16'h0874, 16'h0001, 16'hFFFF);
    periph_request <= 1'b0;
    cfg(16'h2074, 16'h0000, 16'hFFFF);
    go(16'h2074);
    repeat (10) @(posedge core_clk);
    chk(mem.la.size(), 0);
    periph_request <= 1'b1;
    repeat (3) @(posedge core_clk);
    periph_request <= 1'b0;
    verify(16'h2074, 16'h0000, 16'hFFFF);
    cfg(16'h00F4, 16'h0001, 16'hFFFF);
    periph_request <= 1'b1;
    go(16'h00F4);
    n = 0;
    while (mem.la.size() < 6 && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 500) tmo();
    rdchk(IDX4_OFS, 16'h0001);
    chk(chan_clk_en, 1'b1);
    chk(mem.la[4], SRC);
    periph_request <= 1'b0;
    wr(dma_chan_pkg::CHANNEL_CONTROL_OFS, 16'h00F4);
    repeat (20) @(posedge core_clk);
    chk(chan_clk_en, 1'b0);
    rdchk(IDX4_OFS, 16'h0000);
    $display("request test done");
    print_verdict();
  end
endmodule // tb
